/* bench/pfc_link_model.sv */
// link partner model: sends receive frames and paces the transmit stream
`timescale 1ns/10ps
`default_nettype none
module pfc_link_model (
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   input  wire logic         go_i,
   input  wire logic [271:0] frm_i,
   input  wire logic         err_i,
   output logic              busy_o,
   output logic              rx_valid_o,
   output logic [7:0]        rx_data_o,
   output logic              rx_sof_o,
   output logic              rx_eof_o,
   output logic              rx_err_o,
   output logic              tx_ready_o
);
   logic [5:0] idx_r;
   // whole frames only, one byte a cycle
   always_ff @(posedge clk_i) begin
      rx_valid_o <= 1'b0;
      rx_sof_o   <= 1'b0;
      rx_eof_o   <= 1'b0;
      rx_err_o   <= 1'b0;
      // slow partner: accepts a byte every other cycle
      tx_ready_o <= ~reset_i & ~tx_ready_o;
      if (reset_i) begin
         busy_o    <= 1'b0;
         idx_r     <= 6'h00;
         rx_data_o <= 8'h5a;
      end else if (go_i) begin
         busy_o <= 1'b1;
         idx_r  <= 6'h00;
      end else if (busy_o) begin
         rx_valid_o <= 1'b1;
         rx_data_o  <= frm_i[271 - 8 * idx_r -: 8];
         rx_sof_o   <= (idx_r == 6'h00);
         rx_eof_o   <= (idx_r == 6'h21);
         rx_err_o   <= err_i & (idx_r == 6'h21);
         idx_r      <= idx_r + 6'h01;
         busy_o     <= (idx_r != 6'h21);
      end else begin
         // released line shows no stale byte
         rx_data_o <= ~rx_data_o;
      end
   end
endmodule // pfc_link_model
`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench of the pause flow control block
`timescale 1ns/10ps
`default_nettype none
`include "pfc_params.svh"
module tb_top;
   logic clk_i, reset_i, rd_r, wr_r, go_r, err_r, busy_r, mbusy_r, rx_v, rx_s, rx_e, rx_x;
   logic txr, wreq, tx_v, tx_l, hold, irq, rlc;
   logic [7:0] adr_r, rx_d, tx_d, paused;
   logic [31:0] wd_r, rdat, q, lf;
   logic [271:0] frm_r, ex;
   int fail_count, total_checks, n, k, b;
   pfc_top #(.P_QCYC_FAST(4), .P_QCYC_SLOW(8)) i_pfc_top (.clk_i(clk_i), .reset_i(reset_i),
      .avs_address_i(adr_r), .avs_read_i(rd_r), .avs_write_i(wr_r), .avs_writedata_i(wd_r),
      .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
      .rx_valid_i(rx_v), .rx_data_i(rx_d), .rx_sof_i(rx_s), .rx_eof_i(rx_e), .rx_err_i(rx_x),
      .receive_line_clock_i(rlc), .mac_tx_busy_i(mbusy_r), .tx_ready_i(txr),
      .tx_valid_o(tx_v), .tx_data_o(tx_d), .tx_last_o(tx_l), .tx_hold_o(hold),
      .paused_o(paused), .irq_o(irq));
   pfc_link_model i_pfc_link_model (.clk_i(clk_i), .reset_i(reset_i), .go_i(go_r),
      .frm_i(frm_r), .err_i(err_r), .busy_o(busy_r), .rx_valid_o(rx_v), .rx_data_o(rx_d),
      .rx_sof_o(rx_s), .rx_eof_o(rx_e), .rx_err_o(rx_x), .tx_ready_o(txr));
   // verdict and end of run
   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic lim(input int m);
      if (n >= m) begin
         chk("timeout", 0, 1);
         summarize();
      end
   endtask
   // one bus access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      n = 0;
      adr_r <= a;
      wd_r <= d;
      wr_r <= w;
      rd_r <= ~w;
      do begin
         @(posedge clk_i);
         n++;
      end while (wreq !== 1'b0 && n < 20);
      q = rdat;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      lim(20);
      @(posedge clk_i);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask
   // partner sends a frame; status settles after decision
   task automatic send(input logic [271:0] f, input logic e);
      frm_r <= f;
      err_r <= e;
      go_r <= 1'b1;
      @(posedge clk_i);
      go_r <= 1'b0;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (busy_r !== 1'b0 && n < 60);
      lim(60);
      repeat (3) @(posedge clk_i);
   endtask
   function automatic logic [31:0] nx(input logic [31:0] s);
      nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [271:0] mk(input logic [47:0] da, input logic [15:0] ty,
      input logic [15:0] op, input logic [7:0] v, input logic [15:0] t);
      mk = {da, 48'h0a0b_0c0d_0e0f, ty, op, 8'h00, v, {8{t}}};
   endfunction
   // expected generated frame
   function automatic logic [271:0] txf(input logic [7:0] v, input logic [15:0] t,
      input logic z);
      txf = mk(`PFC_DA_RSVD, `PFC_TYPE_CTL, `PFC_OP_PFC, v, 16'h0);
      for (int i = 0; i < 8; i++)
         if (v[i] && !z) txf[127 - 16 * i -: 16] = t;
   endfunction
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // line clock at half the bus clock rate
   always @(posedge clk_i) rlc <= reset_i | ~rlc;
   initial begin
      {reset_i, rd_r, wr_r, go_r, err_r, mbusy_r, adr_r, wd_r, frm_r} = '0;
      reset_i = 1'b1;
      lf = 32'h0001_7110;
      fail_count = 0;
      total_checks = 0;
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      rdc(`PFC_OFF_STAT, 32'h0, "negotiated_rst");
      rdc(8'h30, 32'h0, "unmapped");
      bus(1'b1, `PFC_OFF_NCFG, 32'h0000_0003);
      bus(1'b1, `PFC_OFF_SA1H, 32'h0000_0a0b);
      bus(1'b1, `PFC_OFF_SA1L, 32'h0c0d_0e0f);
      bus(1'b1, `PFC_OFF_IMR, 32'h0000_3000);
      lf = nx(lf);
      k = 4 + lf[2:0];
      send(mk(`PFC_DA_RSVD, `PFC_TYPE_CTL, `PFC_OP_CLASSIC, k[7:0], 16'h0), 1'b0);
      rdc(`PFC_OFF_RXCNT, 32'h0, "rxcnt_off");
      bus(1'b1, `PFC_OFF_NCR, 32'h0001_0000);
      send(mk(`PFC_DA_RSVD, `PFC_TYPE_CTL, `PFC_OP_CLASSIC, k[7:0], 16'h0), 1'b0);
      chk("paused_classic", 32'hff, paused);
      rdc(`PFC_OFF_RXCNT, 32'h1, "rxcnt");
      n = 0;
      while (paused !== 8'h00 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      chk("expiry_window", 1, n >= (k - 2) * 4 && n <= k * 4 + 4);
      chk("irq", 1, irq);
      rdc(`PFC_OFF_ISR, 32'h0000_3000, "isr_rx");
      // bad destination, bad type, errored frame
      for (k = 0; k < 3; k++)
         send(mk(k == 0 ? 48'h0180_c200_0002 : `PFC_DA_RSVD, k == 1 ? 16'h8809 : 16'h8808,
            `PFC_OP_PFC, 8'hff, 16'h0100), k == 2);
      rdc(`PFC_OFF_RXCNT, 32'h1, "rxcnt_bad");
      chk("paused_bad", 32'h0, paused);
      lf = nx(lf);
      send(mk(48'h0a0b_0c0d_0e0f, `PFC_TYPE_CTL, `PFC_OP_PFC, lf[7:0] | 8'h01, 16'h0100), 0);
      chk("paused_pfc", lf[7:0] | 8'h01, paused);
      rdc(`PFC_OFF_ISR, 32'h0000_1000, "isr_pfc");
      rdc(`PFC_OFF_STAT, 32'h1, "negotiated");
      send(mk(`PFC_DA_RSVD, `PFC_TYPE_CTL, `PFC_OP_CLASSIC, 8'hff, 16'h0), 1'b0);
      rdc(`PFC_OFF_RXCNT, 32'h2, "rxcnt_classic");
      bus(1'b1, `PFC_OFF_NCR, 32'h0003_0000);
      repeat (4) @(posedge clk_i);
      chk("hold_txoff", 32'h0, hold);
      bus(1'b1, `PFC_OFF_NCR, 32'h0001_0008);
      for (k = 0; k < 2; k++) begin
         lf = nx(lf);
         bus(1'b1, `PFC_OFF_TXPFC, {lf[31:16], 3'h0, k[0], 4'h0, lf[7:0]});
         ex = txf(lf[7:0], lf[31:16], k[0]);
         mbusy_r <= 1'b1;
         bus(1'b1, `PFC_OFF_NCR, 32'h0003_0008);
         repeat (2) @(posedge clk_i);
         chk("hold", 32'h1, hold);
         chk("tx_early", 32'h0, tx_v);
         mbusy_r <= 1'b0;
         b = 0;
         n = 0;
         while (b < 34 && n < 400) begin
            @(posedge clk_i);
            n++;
            if (tx_v === 1'b1 && txr === 1'b1) begin
               chk("tx_byte", ex[271 - 8 * b -: 8], tx_d);
               chk("tx_last", b == 33, tx_l);
               b++;
            end
         end
         lim(400);
         repeat (3) @(posedge clk_i);
         rdc(`PFC_OFF_ISR, 32'h0000_4000, "isr_tx");
         rdc(`PFC_OFF_TXCNT, k + 1, "txcnt");
      end
      // retry test: counters follow the line clock, then half duplex skips loading
      bus(1'b1, `PFC_OFF_NCFG, 32'h0000_1003);
      send(mk(`PFC_DA_RSVD, `PFC_TYPE_CTL, `PFC_OP_PFC, 8'hff, 16'h0004), 1'b0);
      chk("paused_retry", 32'hff, paused);
      n = 0;
      while (paused !== 8'h00 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      chk("retry_window", 1, n >= 6 && n <= 10);
      rdc(`PFC_OFF_ISR, 32'h0000_3000, "isr_retry");
      bus(1'b1, `PFC_OFF_NCFG, 32'h0000_0001);
      send(mk(`PFC_DA_RSVD, `PFC_TYPE_CTL, `PFC_OP_PFC, 8'hff, 16'h0100), 1'b0);
      chk("paused_half", 32'h0, paused);
      rdc(`PFC_OFF_ISR, 32'h0000_1000, "isr_half");
      rdc(`PFC_OFF_RXCNT, 32'h4, "rxcnt_all");
      summarize();
   end
endmodule // tb_top
`default_nettype wire

/* common/pfc_gen_if.sv */
// link between register side and pause frame generator
`timescale 1ns/10ps
`default_nettype none
interface pfc_gen_if;
   logic        req;
   logic        done;
   logic [7:0]  pev;
   logic        zero_q;
   logic [15:0] quantum;
   logic [47:0] sa;
   modport ctl (output req, output pev, output zero_q, output quantum, output sa, input done);
   modport gen (input req, input pev, input zero_q, input quantum, input sa, output done);
endinterface
`default_nettype wire

/* common/pfc_params.svh */
// constants of the priority pause flow control block
`ifndef PFC_PARAMS_SVH
`define PFC_PARAMS_SVH
// register byte offsets
`define PFC_OFF_NCR    8'h00
`define PFC_OFF_NCFG   8'h04
`define PFC_OFF_ISR    8'h08
`define PFC_OFF_IMR    8'h0c
`define PFC_OFF_SA1L   8'h10
`define PFC_OFF_SA1H   8'h14
`define PFC_OFF_TXPFC  8'h18
`define PFC_OFF_RXCNT  8'h1c
`define PFC_OFF_TXCNT  8'h20
`define PFC_OFF_STAT   8'h24
`define PFC_OFF_PTIME  8'h40
// field positions
`define PFC_NCR_TXEN   3
`define PFC_NCR_PFCRX  16
`define PFC_NCR_PFCTX  17
`define PFC_NCFG_SPD   0
`define PFC_NCFG_FD    1
`define PFC_NCFG_RTY   12
`define PFC_ISR_PNZ    12
`define PFC_ISR_PZ     13
`define PFC_ISR_PTX    14
`define PFC_TXPFC_ZQ   12
`define PFC_TXPFC_QLO  16
// reset values
`define PFC_RST_REG    32'h0000_0000
`define PFC_RST_CNT    16'h0000
// frame constants
`define PFC_DA_RSVD    48'h0180_c200_0001
`define PFC_TYPE_CTL   16'h8808
`define PFC_OP_PFC     16'h0101
`define PFC_OP_CLASSIC 16'h0001
// byte positions in a pause frame
`define PFC_POS_TYPE   6'd12
`define PFC_POS_OP     6'd14
`define PFC_POS_PEV    6'd16
`define PFC_POS_TIME   6'd18
`define PFC_POS_LAST   6'd33
// timing
`define PFC_QUANTUM_BITS 512
`define PFC_BIT_NS_FAST  10
`define PFC_BIT_NS_SLOW  100
`define PFC_CLK_NS       10
`endif

/* common/pfc_pkg.sv */
// types of the priority pause flow control block
package pfc_pkg;
   typedef enum logic [1:0] {
      PFC_TX_IDLE = 2'b00,
      PFC_TX_WAIT = 2'b01,
      PFC_TX_SEND = 2'b10
   } pfc_tx_state_t;
   typedef logic [15:0] pfc_time_t;
endpackage

/* verilog/pfc_top.sv */
// priority pause flow control: register slave, pause receive and pause counters
//
// Operation
// - pfc frames are decoded only while pfc receive enable is set
// - before negotiation both classic and pfc pause frames match
// - after one pfc frame matches, classic pause frames are ignored
// - valid pfc frame loads counters of enabled priorities, even mid pause
// - nonzero quantum sets status bit 12, zero sets 13; masked to irq
// - counters load only in full duplex; half duplex still flags
// - destination must be specific address 1 or reserved multicast
// - type must be 8808 and opcode pfc pause
// - frames with fcs or other errors are discarded
// - each valid pause frame bumps the received counter
// - loaded counters decrement every 512 bit times from frame end
// - retry test: decrement per receive line clock once transmit stops
// - a counter reaching zero sets status bit 13
// - writing control bit 17 sends pfc frame if full duplex and tx on
// - sent frame fields come from the transmit pfc pause register
// - send at once when idle, else between current and next frame
// - sent frame: reserved destination, specific address 1, 8808, 0101
// - after sending, set status bit 14 and bump transmitted counter
// - software pause frames pass the normal transmit path untouched
// - zero quantum control bit 12 sends pause times of zero
`timescale 1ns/10ps
`default_nettype none
`include "pfc_params.svh"
module pfc_top #(
   parameter int unsigned P_QCYC_FAST = `PFC_QUANTUM_BITS * `PFC_BIT_NS_FAST / `PFC_CLK_NS,
   parameter int unsigned P_QCYC_SLOW = `PFC_QUANTUM_BITS * `PFC_BIT_NS_SLOW / `PFC_CLK_NS
) (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic [7:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        rx_valid_i,
   input  wire logic [7:0]  rx_data_i,
   input  wire logic        rx_sof_i,
   input  wire logic        rx_eof_i,
   input  wire logic        rx_err_i,
   input  wire logic        receive_line_clock_i,
   input  wire logic        mac_tx_busy_i,
   input  wire logic        tx_ready_i,
   output logic             tx_valid_o,
   output logic [7:0]       tx_data_o,
   output logic             tx_last_o,
   output logic             tx_hold_o,
   output logic [7:0]       paused_o,
   output logic             irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   pfc_gen_if g ();

   logic [31:0]        ncr_r, ncfg_r, isr_r, imr_r, sa1l_r, sa1h_r, txpfc_r;
   logic [31:0]        rxcnt_r, txcnt_r;
   logic               acc, wr_acc, tx_req;
   logic               negotiated_r;
   logic [5:0]         idx_r;
   logic [47:0]        da_r;
   logic [15:0]        type_r, op_r, pev_r;
   pfc_pkg::pfc_time_t tm_r [8];
   logic               done_r, err_r;
   logic               da_ok, is_pfc, is_cls, accept, nonzero, load_en, isr_rd;
   logic [12:0]        presc_r;
   logic               tick, rlc_d_r, zero_evt;
   logic [7:0]         hit_zero;
   pfc_pkg::pfc_time_t cnt_r [8];

   // true when an address selects a given register
   function automatic logic sel(input logic [7:0] a, input logic [7:0] off);
      sel = (a == off);
   endfunction

   // merge write data under byte enables
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] be);
      for (int b = 0; b < 4; b++) merge[8*b +: 8] = be[b] ? n[8*b +: 8] : o[8*b +: 8];
   endfunction

   // bus handshake: one wait cycle, access at the low edge
   always_ff @(posedge clk_i) begin
      if (reset_i) avs_waitrequest_o <= 1'b1;
      else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) avs_waitrequest_o <= 1'b0;
      else avs_waitrequest_o <= 1'b1;
   end
   assign acc    = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
   assign wr_acc = acc && avs_write_i;

   // read data prepared in the wait cycle
   always_ff @(posedge clk_i) begin
      if (reset_i) avs_readdata_o <= 32'h0000_0000;
      else if (avs_read_i && avs_waitrequest_o) begin
         unique case (avs_address_i)
            `PFC_OFF_NCR:   avs_readdata_o <= ncr_r & ~(32'h1 << `PFC_NCR_PFCTX);
            `PFC_OFF_NCFG:  avs_readdata_o <= ncfg_r;
            `PFC_OFF_ISR:   avs_readdata_o <= isr_r;
            `PFC_OFF_IMR:   avs_readdata_o <= imr_r;
            `PFC_OFF_SA1L:  avs_readdata_o <= sa1l_r;
            `PFC_OFF_SA1H:  avs_readdata_o <= sa1h_r;
            `PFC_OFF_TXPFC: avs_readdata_o <= txpfc_r;
            `PFC_OFF_RXCNT: avs_readdata_o <= rxcnt_r;
            `PFC_OFF_TXCNT: avs_readdata_o <= txcnt_r;
            `PFC_OFF_STAT:  avs_readdata_o <= {31'h0, negotiated_r};
            default: begin
               if (avs_address_i[7:5] == 3'b010 && avs_address_i[1:0] == 2'b00)
                  avs_readdata_o <= {16'h0000, cnt_r[avs_address_i[4:2]]};
               else avs_readdata_o <= 32'h0000_0000;
            end
         endcase
      end
   end

   // software written configuration
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ncr_r   <= `PFC_RST_REG;
         ncfg_r  <= `PFC_RST_REG;
         imr_r   <= `PFC_RST_REG;
         sa1l_r  <= `PFC_RST_REG;
         sa1h_r  <= `PFC_RST_REG;
         txpfc_r <= `PFC_RST_REG;
      end else if (wr_acc) begin
         if (sel(avs_address_i, `PFC_OFF_NCR))
            ncr_r <= merge(ncr_r, avs_writedata_i, avs_byteenable_i);
         if (sel(avs_address_i, `PFC_OFF_NCFG))
            ncfg_r <= merge(ncfg_r, avs_writedata_i, avs_byteenable_i);
         if (sel(avs_address_i, `PFC_OFF_IMR))
            imr_r <= merge(imr_r, avs_writedata_i, avs_byteenable_i);
         if (sel(avs_address_i, `PFC_OFF_SA1L))
            sa1l_r <= merge(sa1l_r, avs_writedata_i, avs_byteenable_i);
         if (sel(avs_address_i, `PFC_OFF_SA1H))
            sa1h_r <= merge(sa1h_r, avs_writedata_i, avs_byteenable_i) & 32'h0000_ffff;
         if (sel(avs_address_i, `PFC_OFF_TXPFC))
            txpfc_r <= merge(txpfc_r, avs_writedata_i, avs_byteenable_i);
      end
   end

   // transmit request only in full duplex with transmitter on
   assign tx_req = wr_acc && sel(avs_address_i, `PFC_OFF_NCR) && avs_byteenable_i[2]
                   && avs_writedata_i[`PFC_NCR_PFCTX] && ncfg_r[`PFC_NCFG_FD]
                   && ncr_r[`PFC_NCR_TXEN];

   // generator fed from transmit pfc register
   always_ff @(posedge clk_i) begin
      if (reset_i) g.req <= 1'b0;
      else g.req <= tx_req;
   end
   assign g.pev     = txpfc_r[7:0];
   assign g.zero_q  = txpfc_r[`PFC_TXPFC_ZQ];
   assign g.quantum = txpfc_r[`PFC_TXPFC_QLO +: 16];
   assign g.sa      = {sa1h_r[15:0], sa1l_r};

   // receive byte position and field capture
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         idx_r  <= 6'd0;
         da_r   <= 48'h0;
         type_r <= 16'h0;
         op_r   <= 16'h0;
         pev_r  <= 16'h0;
      end else if (rx_valid_i) begin
         idx_r <= rx_sof_i ? 6'd1 : (idx_r == 6'd63 ? idx_r : idx_r + 6'd1);
         if (rx_sof_i) da_r <= {40'h0, rx_data_i};
         else if (idx_r < 6'd6) da_r <= {da_r[39:0], rx_data_i};
         if (idx_r == `PFC_POS_TYPE || idx_r == `PFC_POS_TYPE + 6'd1)
            type_r <= {type_r[7:0], rx_data_i};
         if (idx_r == `PFC_POS_OP || idx_r == `PFC_POS_OP + 6'd1)
            op_r <= {op_r[7:0], rx_data_i};
         if (idx_r == `PFC_POS_PEV || idx_r == `PFC_POS_PEV + 6'd1)
            pev_r <= {pev_r[7:0], rx_data_i};
      end
   end

   // pause time fields, two bytes each
   for (genvar i = 0; i < 8; i++) begin : g_time
      always_ff @(posedge clk_i) begin
         if (reset_i) tm_r[i] <= `PFC_RST_CNT;
         else if (rx_valid_i && (idx_r == `PFC_POS_TIME + 6'(2*i) ||
                                 idx_r == `PFC_POS_TIME + 6'(2*i+1)))
            tm_r[i] <= {tm_r[i][7:0], rx_data_i};
      end
   end

   // end of frame marker with its error flag
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         done_r <= 1'b0;
         err_r  <= 1'b0;
      end else begin
         done_r <= rx_valid_i && rx_eof_i;
         err_r  <= rx_err_i;
      end
   end

   assign da_ok  = (da_r == `PFC_DA_RSVD) || (da_r == {sa1h_r[15:0], sa1l_r});
   assign is_pfc = (op_r == `PFC_OP_PFC);
   assign is_cls = (op_r == `PFC_OP_CLASSIC);
   assign accept = done_r && !err_r && ncr_r[`PFC_NCR_PFCRX] && da_ok
                   && type_r == `PFC_TYPE_CTL && (is_pfc || (is_cls && !negotiated_r));
   always_comb begin
      nonzero = 1'b0;
      for (int i = 0; i < 8; i++) if (pev_r[i] && tm_r[i] != 16'h0) nonzero = 1'b1;
      if (is_cls) nonzero = (pev_r != 16'h0);
   end
   assign load_en = accept && ncfg_r[`PFC_NCFG_FD];

   always_ff @(posedge clk_i) begin
      if (reset_i) negotiated_r <= 1'b0;
      else if (accept && is_pfc) negotiated_r <= 1'b1;
   end

   // 512 bit time prescaler restarts on load
   always_ff @(posedge clk_i) begin
      if (reset_i) presc_r <= 13'd0;
      else if (load_en || presc_r == 13'd0)
         presc_r <= ncfg_r[`PFC_NCFG_SPD] ? 13'(P_QCYC_FAST - 1) : 13'(P_QCYC_SLOW - 1);
      else presc_r <= presc_r - 13'd1;
   end

   // receive line clock edge sampling
   always_ff @(posedge clk_i) begin
      if (reset_i) rlc_d_r <= 1'b0;
      else rlc_d_r <= receive_line_clock_i;
   end

   // test mode tick on line clock once transmit stops
   assign tick = ncfg_r[`PFC_NCFG_RTY] ? (receive_line_clock_i && !rlc_d_r && !mac_tx_busy_i)
                                       : (presc_r == 13'd0 && !load_en);

   for (genvar i = 0; i < 8; i++) begin : g_cnt
      always_ff @(posedge clk_i) begin
         if (reset_i) cnt_r[i] <= `PFC_RST_CNT;
         else if (load_en && is_pfc && pev_r[i]) cnt_r[i] <= tm_r[i];
         else if (load_en && is_cls) cnt_r[i] <= pev_r;
         else if (tick && cnt_r[i] != 16'h0) cnt_r[i] <= cnt_r[i] - 16'd1;
      end
      assign hit_zero[i] = tick && cnt_r[i] == 16'd1 && !(load_en && (is_cls || pev_r[i]));
   end
   assign zero_evt = |hit_zero;

   // paused priorities shown to the transmit scheduler
   always_ff @(posedge clk_i) begin
      if (reset_i) paused_o <= 8'h00;
      else for (int i = 0; i < 8; i++) paused_o[i] <= cnt_r[i] != 16'h0;
   end

   // sticky status, clear on read, set wins
   // a read clears only the bits it returned, so an event in the wait cycle is kept
   assign isr_rd = acc && avs_read_i && sel(avs_address_i, `PFC_OFF_ISR);
   always_ff @(posedge clk_i) begin
      if (reset_i) isr_r <= `PFC_RST_REG;
      else begin
         isr_r <= isr_rd ? (isr_r & ~avs_readdata_o) : isr_r;
         isr_r[`PFC_ISR_PNZ] <= (accept && nonzero) ||
            (isr_r[`PFC_ISR_PNZ] && !(isr_rd && avs_readdata_o[`PFC_ISR_PNZ]));
         isr_r[`PFC_ISR_PZ]  <= (accept && !nonzero) || zero_evt ||
            (isr_r[`PFC_ISR_PZ] && !(isr_rd && avs_readdata_o[`PFC_ISR_PZ]));
         isr_r[`PFC_ISR_PTX] <= g.done ||
            (isr_r[`PFC_ISR_PTX] && !(isr_rd && avs_readdata_o[`PFC_ISR_PTX]));
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) irq_o <= 1'b0;
      else irq_o <= |(isr_r & imr_r);
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rxcnt_r <= `PFC_RST_REG;
         txcnt_r <= `PFC_RST_REG;
      end else begin
         if (accept) rxcnt_r <= rxcnt_r + 32'd1;
         if (g.done) txcnt_r <= txcnt_r + 32'd1;
      end
   end

   pfc_txgen u_txgen (
      .clk_i         (clk_i),
      .reset_i       (reset_i),
      .g             (g.gen),
      .mac_tx_busy_i (mac_tx_busy_i),
      .tx_ready_i    (tx_ready_i),
      .tx_valid_o    (tx_valid_o),
      .tx_data_o     (tx_data_o),
      .tx_last_o     (tx_last_o),
      .tx_hold_o     (tx_hold_o)
   );

   sequence s_rx_accept;
      accept ##1 1'b1;
   endsequence

   AST_RX_DISABLED: assert property (!ncr_r[`PFC_NCR_PFCRX] |-> !accept)
      else $error("pause frame accepted with pfc receive off");
   AST_NEG_CLASSIC: assert property (negotiated_r && is_cls |-> !accept)
      else $error("classic pause accepted after negotiation");
   AST_IRQ_NZ: assert property (accept && nonzero |=> isr_r[`PFC_ISR_PNZ])
      else $error("nonzero pause did not set status bit 12");
   AST_HALF_DUPLEX: assert property (accept && !ncfg_r[`PFC_NCFG_FD] |-> !load_en)
      else $error("counters loaded in half duplex");
   AST_BAD_DA: assert property (done_r && !da_ok |-> !accept)
      else $error("pause accepted with wrong destination");
   AST_BAD_ERR: assert property (done_r && err_r |-> !accept)
      else $error("errored pause frame accepted");
   AST_RX_STAT: assert property (s_rx_accept |-> rxcnt_r == $past(rxcnt_r) + 32'd1)
      else $error("received counter did not advance");
   AST_ZERO_IRQ: assert property (zero_evt |=> isr_r[`PFC_ISR_PZ])
      else $error("counter reached zero without status bit 13");
   AST_TX_GATE: assert property (g.req |-> $past(ncfg_r[`PFC_NCFG_FD]))
      else $error("pfc send requested outside full duplex");
   AST_TX_DONE: assert property (g.done |=> isr_r[`PFC_ISR_PTX] ##0 txcnt_r != $past(txcnt_r))
      else $error("sent pause not flagged or counted");
endmodule // pfc_top
`default_nettype wire

/* verilog/pfc_txgen.sv */
// pause frame generator inserted between transmit frames
`timescale 1ns/10ps
`default_nettype none
`include "pfc_params.svh"
module pfc_txgen (
   input  wire logic  clk_i,
   input  wire logic  reset_i,
   pfc_gen_if.gen     g,
   input  wire logic  mac_tx_busy_i,
   input  wire logic  tx_ready_i,
   output logic       tx_valid_o,
   output logic [7:0] tx_data_o,
   output logic       tx_last_o,
   output logic       tx_hold_o
);
   pfc_pkg::pfc_tx_state_t state_r;
   logic [5:0]             idx_r;
   logic                   adv;

   // byte of the generated frame at a position
   function automatic logic [7:0] frame_byte(input logic [5:0] i);
      logic [15:0] t;
      t = g.zero_q ? 16'h0000 : g.quantum;
      if (i < 6'd6) frame_byte = 8'(`PFC_DA_RSVD >> (8 * (5 - i)));
      else if (i < `PFC_POS_TYPE) frame_byte = 8'(g.sa >> (8 * (11 - i)));
      else if (i < `PFC_POS_OP) frame_byte = 8'(`PFC_TYPE_CTL >> (8 * (13 - i)));
      else if (i < `PFC_POS_PEV) frame_byte = 8'(`PFC_OP_PFC >> (8 * (15 - i)));
      else if (i == `PFC_POS_PEV) frame_byte = 8'h00;
      else if (i < `PFC_POS_TIME) frame_byte = g.pev;
      else if (!g.pev[3'((i - `PFC_POS_TIME) >> 1)]) frame_byte = 8'h00;
      else if (i[0] == 1'b0) frame_byte = t[15:8];
      else frame_byte = t[7:0];
   endfunction

   assign adv = (state_r == pfc_pkg::PFC_TX_SEND) && tx_ready_i;

   // state and byte position
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_r <= pfc_pkg::PFC_TX_IDLE;
         idx_r   <= 6'd0;
      end else begin
         unique case (state_r)
            pfc_pkg::PFC_TX_IDLE: begin
               if (g.req) state_r <= pfc_pkg::PFC_TX_WAIT;
            end
            pfc_pkg::PFC_TX_WAIT: begin
               if (!mac_tx_busy_i) begin
                  state_r <= pfc_pkg::PFC_TX_SEND;
                  idx_r   <= 6'd0;
               end
            end
            pfc_pkg::PFC_TX_SEND: begin
               if (adv && idx_r == `PFC_POS_LAST) state_r <= pfc_pkg::PFC_TX_IDLE;
               else if (adv) idx_r <= idx_r + 6'd1;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         tx_valid_o <= 1'b0;
         tx_data_o  <= 8'h00;
         tx_last_o  <= 1'b0;
         g.done     <= 1'b0;
      end else begin
         g.done <= adv && idx_r == `PFC_POS_LAST;
         if (state_r == pfc_pkg::PFC_TX_WAIT && !mac_tx_busy_i) begin
            tx_valid_o <= 1'b1;
            tx_data_o  <= frame_byte(6'd0);
            tx_last_o  <= 1'b0;
         end else if (adv && idx_r == `PFC_POS_LAST) begin
            tx_valid_o <= 1'b0;
            tx_last_o  <= 1'b0;
         end else if (adv) begin
            tx_data_o <= frame_byte(idx_r + 6'd1);
            tx_last_o <= (idx_r + 6'd1) == `PFC_POS_LAST;
         end
      end
   end

   // hold off the next queued frame
   always_ff @(posedge clk_i) begin
      if (reset_i) tx_hold_o <= 1'b0;
      else tx_hold_o <= (state_r != pfc_pkg::PFC_TX_IDLE) || g.req;
   end

   AST_TX_WAIT_GAP: assert property (@(posedge clk_i) disable iff (reset_i)
      state_r == pfc_pkg::PFC_TX_WAIT && mac_tx_busy_i |=> state_r == pfc_pkg::PFC_TX_WAIT)
      else $error("pause frame started while transmitter busy");
   AST_TX_DA_FIRST: assert property (@(posedge clk_i) disable iff (reset_i)
      state_r == pfc_pkg::PFC_TX_SEND && idx_r == 6'd0 |-> tx_data_o == 8'h01 && tx_valid_o)
      else $error("generated frame does not open with reserved address");
endmodule // pfc_txgen
`default_nettype wire
